// ==== hdl/srm_pkg.sv ====
`default_nettype none
package srm_pkg;
    localparam int unsigned CLK_HZ        = 250_000_000;
    localparam int unsigned BAUD_BPS      = 9600;
    localparam int unsigned BIT_CYC       = CLK_HZ / BAUD_BPS;
    localparam int unsigned HALF_CYC      = BIT_CYC / 2;
    localparam int unsigned DATA_BITS     = 8;
    localparam int unsigned STOP_BITS     = 1;
    localparam int unsigned FIFO_DEPTH    = 16;
    localparam logic [7:0]  CMD_ENTER     = 8'h80;
    localparam logic [7:0]  CMD_EXIT      = 8'h81;
    localparam logic [7:0]  ACK_BYTE      = 8'h21;
    localparam logic        MODE_LOCAL    = 1'b0;
    localparam logic        MODE_REMOTE   = 1'b1;
    localparam logic [15:0] BIT_CNT_LAST  = 16'(BIT_CYC - 1);
    localparam logic [15:0] HALF_CNT_LAST = 16'(HALF_CYC - 1);
    localparam logic [3:0]  LAST_DATA_BIT = 4'(DATA_BITS - 1);
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} srm_rx_t;
    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} srm_tx_t;
endpackage
`default_nettype wire

// ==== hdl/srm_fifo.sv ====
`default_nettype none
module srm_fifo
    import srm_pkg::*;
#(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 16
)(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW:0]      wr_ptr_ff;
    logic [AW:0]      rd_ptr_ff;
    wire              do_wr = in_valid && in_ready;
    wire              do_rd = out_valid && out_ready;
    // full when pointers differ only in wrap bit
    assign in_ready  = (wr_ptr_ff ^ rd_ptr_ff) != {1'b1, {AW{1'b0}}};
    assign out_valid = wr_ptr_ff != rd_ptr_ff;
    assign out_data  = mem_ff[rd_ptr_ff[AW-1:0]];
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end
        else
        begin
            if (do_wr)
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            if (do_rd)
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
        end
    end
    always_ff @(posedge clk)
    begin
        if (do_wr)
            mem_ff[wr_ptr_ff[AW-1:0]] <= in_data;
    end
endmodule
`default_nettype wire

// ==== hdl/srm_top.sv ====
`default_nettype none
module srm_top
    import srm_pkg::*;
#(
    parameter int unsigned BIT_CYCLES = BIT_CYC
)(
    input  wire logic CORE_CLK,
    input  wire logic SYS_RST,
    input  wire logic RXD,
    output logic      TXD,
    output logic      REMOTE_MODE,
    output logic      FRAME_ERR
);
    // rx input sync
    logic        rx_meta_ff;
    logic        rx_sync_ff;
    srm_rx_t     rx_st_ff;
    logic [15:0] rx_cnt_ff;
    logic [3:0]  rx_bit_ff;
    logic [7:0]  rx_sh_ff;
    logic        rx_done_ff;
    logic        ferr_ff;
    logic        mode_ff;
    logic        ack_push_ff;
    srm_tx_t     tx_st_ff;
    logic [15:0] tx_cnt_ff;
    logic [3:0]  tx_bit_ff;
    logic [7:0]  tx_sh_ff;
    logic        txd_ff;
    logic        fifo_in_ready;
    logic [7:0]  fifo_out_data;
    logic        fifo_out_valid;

    // bit time open to scaling so a bench run stays short; default is the real rate
    localparam logic [15:0] BIT_LAST  = 16'(BIT_CYCLES - 1);
    localparam logic [15:0] HALF_LAST = 16'(BIT_CYCLES / 2 - 1);

    wire rx_tick      = rx_cnt_ff == BIT_LAST;
    wire rx_half      = rx_cnt_ff == HALF_LAST;
    wire tx_tick      = tx_cnt_ff == BIT_LAST;
    wire is_enter     = rx_done_ff && rx_sh_ff == CMD_ENTER;
    wire is_exit      = rx_done_ff && rx_sh_ff == CMD_EXIT;
    // only a real change of the flag is acknowledged
    wire go_remote    = is_enter && mode_ff == MODE_LOCAL;
    wire go_local     = is_exit && mode_ff == MODE_REMOTE;
    wire tx_take      = tx_st_ff == TX_IDLE && fifo_out_valid;
    wire fifo_ready_w = tx_take;

    always_ff @(posedge CORE_CLK)
    begin
        if (SYS_RST)
        begin
            rx_meta_ff <= 1'b1;
            rx_sync_ff <= 1'b1;
        end
        else
        begin
            rx_meta_ff <= RXD;
            rx_sync_ff <= rx_meta_ff;
        end
    end

    // receiver: sample at mid bit, no parity
    always_ff @(posedge CORE_CLK)
    begin
        if (SYS_RST)
        begin
            rx_st_ff   <= RX_IDLE;
            rx_cnt_ff  <= '0;
            rx_bit_ff  <= '0;
            rx_sh_ff   <= '0;
            rx_done_ff <= 1'b0;
            ferr_ff    <= 1'b0;
        end
        else
        begin
            rx_done_ff <= 1'b0;
            unique case (rx_st_ff)
                RX_IDLE:
                begin
                    rx_cnt_ff <= '0;
                    if (!rx_sync_ff)
                        rx_st_ff <= RX_START;
                end
                RX_START:
                begin
                    rx_cnt_ff <= rx_cnt_ff + 16'h0001;
                    if (rx_half)
                    begin
                        rx_cnt_ff <= '0;
                        rx_bit_ff <= '0;
                        // glitch shorter than half a bit is dropped
                        rx_st_ff  <= rx_sync_ff ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA:
                begin
                    rx_cnt_ff <= rx_tick ? 16'h0000 : rx_cnt_ff + 16'h0001;
                    if (rx_tick)
                    begin
                        rx_sh_ff  <= {rx_sync_ff, rx_sh_ff[7:1]};
                        rx_bit_ff <= rx_bit_ff + 4'h1;
                        if (rx_bit_ff == LAST_DATA_BIT)
                            rx_st_ff <= RX_STOP;
                    end
                end
                RX_STOP:
                begin
                    rx_cnt_ff <= rx_tick ? 16'h0000 : rx_cnt_ff + 16'h0001;
                    if (rx_tick)
                    begin
                        rx_st_ff   <= RX_IDLE;
                        rx_done_ff <= rx_sync_ff;
                        ferr_ff    <= !rx_sync_ff;
                    end
                end
            endcase
        end
    end

    // mode flag and acknowledge request
    always_ff @(posedge CORE_CLK)
    begin
        if (SYS_RST)
        begin
            mode_ff     <= MODE_LOCAL;
            ack_push_ff <= 1'b0;
        end
        else
        begin
            ack_push_ff <= 1'b0;
            if (go_remote)
            begin
                mode_ff     <= MODE_REMOTE;
                ack_push_ff <= fifo_in_ready;
            end
            else if (go_local)
            begin
                mode_ff     <= MODE_LOCAL;
                ack_push_ff <= fifo_in_ready;
            end
        end
    end

    srm_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (CORE_CLK),
        .rst       (SYS_RST),
        .in_data   (ACK_BYTE),
        .in_valid  (ack_push_ff),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_ready_w)
    );

    // transmitter: start, eight data lsb first, one stop
    always_ff @(posedge CORE_CLK)
    begin
        if (SYS_RST)
        begin
            tx_st_ff  <= TX_IDLE;
            tx_cnt_ff <= '0;
            tx_bit_ff <= '0;
            tx_sh_ff  <= '0;
            txd_ff    <= 1'b1;
        end
        else
        begin
            tx_cnt_ff <= (tx_tick || tx_st_ff == TX_IDLE) ? 16'h0000 : tx_cnt_ff + 16'h0001;
            unique case (tx_st_ff)
                TX_IDLE:
                begin
                    txd_ff <= 1'b1;
                    if (tx_take)
                    begin
                        tx_sh_ff <= fifo_out_data;
                        txd_ff   <= 1'b0;
                        tx_st_ff <= TX_START;
                    end
                end
                TX_START:
                    if (tx_tick)
                    begin
                        txd_ff    <= tx_sh_ff[0];
                        tx_sh_ff  <= {1'b0, tx_sh_ff[7:1]};
                        tx_bit_ff <= '0;
                        tx_st_ff  <= TX_DATA;
                    end
                TX_DATA:
                    if (tx_tick)
                    begin
                        tx_bit_ff <= tx_bit_ff + 4'h1;
                        if (tx_bit_ff == LAST_DATA_BIT)
                        begin
                            txd_ff   <= 1'b1;
                            tx_st_ff <= TX_STOP;
                        end
                        else
                        begin
                            txd_ff   <= tx_sh_ff[0];
                            tx_sh_ff <= {1'b0, tx_sh_ff[7:1]};
                        end
                    end
                TX_STOP:
                    if (tx_tick)
                        tx_st_ff <= TX_IDLE;
            endcase
        end
    end

    assign TXD         = txd_ff;
    assign REMOTE_MODE = mode_ff;
    assign FRAME_ERR   = ferr_ff;

    // no reply when entering while already remote
    enter_repeat_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        is_enter && mode_ff |=> !ack_push_ff)
        else $error("reply pushed for repeated enter");
    exit_repeat_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        is_exit && !mode_ff |=> !ack_push_ff && !mode_ff)
        else $error("reply pushed for repeated exit");
    enter_ack_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        is_enter && !mode_ff && fifo_in_ready |=> ack_push_ff && mode_ff)
        else $error("enter not acknowledged");
    exit_ack_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        is_exit && mode_ff && fifo_in_ready |=> ack_push_ff && !mode_ff)
        else $error("exit not acknowledged");
    ack_cause_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        ack_push_ff |-> mode_ff != $past(mode_ff))
        else $error("reply without mode change");
    mode_reset_a: assert property (@(posedge CORE_CLK)
        $past(SYS_RST) |-> !mode_ff)
        else $error("mode not local after reset");
    sequence tx_begin_s;
        tx_take ##1 !txd_ff;
    endsequence
    tx_frame_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        tx_begin_s |-> !txd_ff [*8])
        else $error("start bit too short");
    tx_idle_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        tx_st_ff == TX_IDLE && !tx_take |=> txd_ff)
        else $error("line not idle high");
endmodule
`default_nettype wire

// ==== tb/srm_host.sv ====
`default_nettype none
module srm_host
    import srm_pkg::*;
#(
    parameter int unsigned BIT_CYCLES = BIT_CYC
)(
    input  wire logic clk,
    input  wire logic txd,
    output logic      rxd
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] got_q[$];
    logic       last_stop;
    // start bits seen, so a reply is caught before its frame ends
    int unsigned starts;

    initial
    begin
        rxd = 1'b1;
        last_stop = 1'b1;
        starts = 0;
    end

    task automatic bit_wait();
        repeat (BIT_CYCLES) @(posedge clk);
        #1;
    endtask

    // lsb first, no parity; stop level chosen so a bad frame can be sent
    task automatic send(input logic [7:0] b, input logic stop_bit);
        @(posedge clk);
        #1;
        rxd = 1'b0;
        bit_wait();
        for (int i = 0; i < 8; i++)
        begin
            rxd = b[i];
            bit_wait();
        end
        rxd = stop_bit;
        bit_wait();
        rxd = 1'b1;
    endtask

    // samples mid bit, same as a real port would
    initial
    begin : rx_loop
        logic [7:0] b;
        forever
        begin
            @(negedge txd);
            starts++;
            repeat (BIT_CYCLES / 2) @(posedge clk);
            for (int i = 0; i < 8; i++)
            begin
                repeat (BIT_CYCLES) @(posedge clk);
                b[i] = txd;
            end
            repeat (BIT_CYCLES) @(posedge clk);
            last_stop = txd;
            got_q.push_back(b);
        end
    end
endmodule
`default_nettype wire

// ==== tb/test_serial_remote_mode_control.sv ====
`default_nettype none
module test_serial_remote_mode_control;
    import srm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic core_clk, sys_rst, rxd, txd, remote_mode, frame_err;
    int   miscompares = 0;
    int   total_checks = 0;

    // scaled bit time: the real rate would need far too many cycles per byte
    localparam int unsigned TB_BIT = 64;

    srm_top #(.BIT_CYCLES(TB_BIT)) u_srm_top (.CORE_CLK(core_clk), .SYS_RST(sys_rst), .RXD(rxd), .TXD(txd),
                                              .REMOTE_MODE(remote_mode), .FRAME_ERR(frame_err));
    srm_host #(.BIT_CYCLES(TB_BIT)) u_srm_host (.clk(core_clk), .txd(txd), .rxd(rxd));

    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("checks=%0d miscompares=%0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // reply would start a few cycles after the stop sample, so two bit times prove silence
    task automatic do_cmd(input logic [7:0] b, input logic stp_in, input logic ack,
                          output logic [7:0] cnt, output logic [7:0] rep);
        int n;
        int lim;
        n = 0;
        lim = ack ? 11 * TB_BIT : 2 * TB_BIT;
        rep = 8'h00;
        u_srm_host.got_q.delete();
        u_srm_host.starts = 0;
        u_srm_host.send(b, stp_in);
        while (u_srm_host.got_q.size() == 0 && n < lim)
        begin
            @(posedge core_clk);
            n++;
        end
        #1;
        cnt = 8'(u_srm_host.starts);
        if (ack && u_srm_host.got_q.size() == 0)
        begin
            miscompares++;
            results();
        end
        if (u_srm_host.got_q.size() != 0)
            rep = u_srm_host.got_q[0];
    endtask

    task automatic t_reset();
        check({7'h0, txd}, 8'h01);
        check({7'h0, remote_mode}, 8'h00);
        check({7'h0, frame_err}, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_reset_remote();
        logic [7:0] cnt, rep;
        do_cmd(CMD_ENTER, 1'b1, 1'b1, cnt, rep);
        check(cnt, 8'h01);
        check({7'h0, remote_mode}, 8'h01);
        @(posedge core_clk);
        #1;
        sys_rst = 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
        sys_rst = 1'b0;
        check({7'h0, remote_mode}, 8'h00);
        check({7'h0, txd}, 8'h01);
        do_cmd(CMD_EXIT, 1'b1, 1'b0, cnt, rep);
        check(cnt, 8'h00);
        check({7'h0, remote_mode}, 8'h00);
        $display("test reset while remote done");
    endtask

    task automatic t_exit_local();
        logic [7:0] cnt, rep;
        do_cmd(CMD_EXIT, 1'b1, 1'b0, cnt, rep);
        check(cnt, 8'h00);
        check({7'h0, remote_mode}, 8'h00);
        $display("test exit while local done");
    endtask

    task automatic t_enter();
        logic [7:0] cnt, rep;
        do_cmd(CMD_ENTER, 1'b1, 1'b1, cnt, rep);
        check(cnt, 8'h01);
        check(rep, ACK_BYTE);
        check({7'h0, u_srm_host.last_stop}, 8'h01);
        check({7'h0, remote_mode}, 8'h01);
        $display("test enter done");
    endtask

    task automatic t_enter_again();
        logic [7:0] cnt, rep;
        do_cmd(CMD_ENTER, 1'b1, 1'b0, cnt, rep);
        check(cnt, 8'h00);
        check({7'h0, remote_mode}, 8'h01);
        check({7'h0, txd}, 8'h01);
        $display("test enter again done");
    endtask

    task automatic t_bad_frames();
        logic [7:0] cnt, rep;
        do_cmd(CMD_EXIT, 1'b0, 1'b0, cnt, rep);
        check(cnt, 8'h00);
        check({7'h0, frame_err}, 8'h01);
        check({7'h0, remote_mode}, 8'h01);
        do_cmd(8'h55, 1'b1, 1'b0, cnt, rep);
        check(cnt, 8'h00);
        check({7'h0, frame_err}, 8'h00);
        check({7'h0, remote_mode}, 8'h01);
        $display("test bad frames done");
    endtask

    task automatic t_exit_twice();
        logic [7:0] cnt, rep;
        do_cmd(CMD_EXIT, 1'b1, 1'b1, cnt, rep);
        check(cnt, 8'h01);
        check(rep, ACK_BYTE);
        check({7'h0, remote_mode}, 8'h00);
        do_cmd(CMD_EXIT, 1'b1, 1'b0, cnt, rep);
        check(cnt, 8'h00);
        do_cmd(CMD_EXIT, 1'b1, 1'b0, cnt, rep);
        check(cnt, 8'h00);
        check({7'h0, remote_mode}, 8'h00);
        $display("test exit twice done");
    endtask

    initial
    begin
        sys_rst = 1'b1;
        repeat (6) @(posedge core_clk);
        #1;
        sys_rst = 1'b0;
        t_reset();
        t_exit_local();
        t_enter();
        t_enter_again();
        t_bad_frames();
        t_exit_twice();
        t_reset_remote();
        results();
    end
endmodule
`default_nettype wire
